// [logic/i2c_bus_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "i2c_ctl_cfg.svh"

module i2c_bus_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// control
	input wire logic enable,
	// raw bus levels
	input wire logic sclIn,
	input wire logic sdaIn,
	// detected events and state
	output logic sclLevel,
	output logic sdaLevel,
	output logic busBusy,
	output logic addrPhase,
	output logic [7:0] rxByte,
	output logic ackLow,
	output logic startSeen,
	output logic stopSeen,
	output logic fall8,
	output logic fall9,
	output logic rise9
);

	i2c_ctl_pkg::mon_state_t q, d;
	logic scl;
	logic sda;

	// --------------------------------------------------------------
	// bus condition and clock edge detection
	// --------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.sclSync = {q.sclSync[0], sclIn};
		d.sdaSync = {q.sdaSync[0], sdaIn};
		scl = q.sclSync[1];
		sda = q.sdaSync[1];
		d.sclLast = scl;
		d.sdaLast = sda;
		d.startSeen = 1'b0;
		d.stopSeen = 1'b0;
		d.fall8 = 1'b0;
		d.fall9 = 1'b0;
		d.rise9 = 1'b0;
		// address phase holds through the ninth fall so that edge still sees it
		if (q.fall9)
			d.addrPhase = 1'b0;
		if (!enable)
		begin
			d.busBusy = 1'b0;
			d.addrPhase = 1'b0;
			d.fallCount = 4'h0;
		end
		else if (scl && q.sclLast && q.sdaLast && !sda)
		begin
			d.busBusy = 1'b1;
			d.addrPhase = 1'b1;
			d.fallCount = `MON_PRE;
			d.startSeen = 1'b1;
		end
		else if (scl && q.sclLast && !q.sdaLast && sda)
		begin
			d.busBusy = 1'b0;
			d.addrPhase = 1'b0;
			d.fallCount = 4'h0;
			d.stopSeen = 1'b1;
		end
		else if (scl && !q.sclLast)
		begin
			if (q.fallCount < 4'h8)
				d.rxByte = {q.rxByte[6:0], sda};
			else if (q.fallCount == 4'h8)
			begin
				d.ackLow = !sda;
				d.rise9 = 1'b1;
			end
		end
		else if (!scl && q.sclLast && q.busBusy)
		begin
			if (q.fallCount == `MON_PRE)
				d.fallCount = 4'h0;
			else if (q.fallCount == 4'h7)
			begin
				d.fallCount = 4'h8;
				d.fall8 = 1'b1;
			end
			else if (q.fallCount == 4'h8)
			begin
				d.fallCount = 4'h0;
				d.fall9 = 1'b1;
			end
			else
				d.fallCount = q.fallCount + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			// idle bus is high: no false edge once reset lets go
			q.sclSync <= 2'b11;
			q.sdaSync <= 2'b11;
			q.sclLast <= 1'b1;
			q.sdaLast <= 1'b1;
		end
		else if (clkEn)
			q <= d;
	end

	assign sclLevel = q.sclSync[1];
	assign sdaLevel = q.sdaSync[1];
	assign busBusy = q.busBusy;
	assign addrPhase = q.addrPhase;
	assign rxByte = q.rxByte;
	assign ackLow = q.ackLow;
	assign startSeen = q.startSeen;
	assign stopSeen = q.stopSeen;
	assign fall8 = q.fall8;
	assign fall9 = q.fall9;
	assign rise9 = q.rise9;

endmodule

`default_nettype wire

// [logic/i2c_control_register.sv]
//
// Overview of operation
// - control register sits at FFA6H and resets to 00H
// - software writes the register as a byte or as a single bit
// - bits 7..0: enable, exit, wait release, stop irq, wait timing, ack, start, stop
// - enable low stops all operation and holds status cleared
// - enable low also clears start-failed, bus-busy, clock and data level bits
// - exit bit abandons transfer, enters standby, then clears itself
// - exit action releases both clock and data lines
// - exit clears stop (kept if a stop is seen that cycle), ack, transmit, match, extension, master flags and triggers
// - standby lasts until a stop, or a start followed by match or extension
// - standby ends when a start is followed by address match or extension code
// - wait release bit frees the clock line and clears itself
// - release during ninth-clock wait while transmitting frees data, clears transmit
// - with enable low, exit, wait release and stop irq bits are ignored
// - stop irq enable raises the interrupt when a stop is detected
// - start trigger bit issues a start condition on the bus when it is free; if the bus is busy it sets start-failed instead
// - wait timing selects wait and interrupt at eighth or ninth falling edge of data bytes
//
`timescale 1ns/100ps
`default_nettype none
`include "i2c_ctl_cfg.svh"

module i2c_control_register (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// cpu register access
	input wire logic [15:0] cpuAddr,
	input wire logic cpuWrByte,
	input wire logic [7:0] cpuWrData,
	input wire logic cpuWrBit,
	input wire logic [2:0] cpuBitSel,
	input wire logic cpuBitVal,
	input wire logic cpuRd,
	output logic [7:0] cpuRdData,
	// local configuration and transmit data
	input wire logic [6:0] slaveAddr,
	input wire logic txFirstBit,
	// serial clock pin
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	// serial data pin
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// status towards neighbouring registers
	output logic [7:0] statusReg,
	output logic startFailed,
	output logic busBusy,
	output logic clockLineLevel,
	output logic dataLineLevel,
	// interrupt request
	output logic twoWireInterrupt
);

	i2c_ctl_pkg::ctl_state_t q, d;

	logic sclLevel;
	logic sdaLevel;
	logic monBusy;
	logic addrPhase;
	logic [7:0] rxByte;
	logic ackLow;
	logic startSeen;
	logic stopSeen;
	logic fall8;
	logic fall9;
	logic rise9;
	logic enabled;
	logic hit;
	logic matchNow;
	logic extNow;
	logic involved;
	logic waitAt8;

	// --------------------------------------------------------------
	// bus monitor
	// --------------------------------------------------------------
	i2c_bus_monitor monitor (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.enable(enabled),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sclLevel(sclLevel),
		.sdaLevel(sdaLevel),
		.busBusy(monBusy),
		.addrPhase(addrPhase),
		.rxByte(rxByte),
		.ackLow(ackLow),
		.startSeen(startSeen),
		.stopSeen(stopSeen),
		.fall8(fall8),
		.fall9(fall9),
		.rise9(rise9)
	);

	// --------------------------------------------------------------
	// control and status next state
	// --------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.irq = 1'b0;
		hit = (cpuAddr == `CTRL_ADDR);
		matchNow = (rxByte[7:1] == slaveAddr);
		extNow = (rxByte[7:3] == `EXT_CODE_PREFIX);
		involved = q.masterSt | q.addrMatch | q.extCode;
		waitAt8 = 1'b0;
		if (!enabled)
		begin
			d.stopDet = 1'b0;
			d.ackDet = 1'b0;
			d.txMode = 1'b0;
			d.addrMatch = 1'b0;
			d.extCode = 1'b0;
			d.masterSt = 1'b0;
			d.startFailed = 1'b0;
			d.standby = 1'b0;
			d.waitHold = 1'b0;
			d.wait9 = 1'b0;
			d.ackDrive = 1'b0;
			d.genState = i2c_ctl_pkg::GEN_IDLE;
			d.holdCount = 9'h000;
			d.ctrl[`BIT_EXIT] = 1'b0;
			d.ctrl[`BIT_WREL] = 1'b0;
		end
		else
		begin
			// bus events
			if (startSeen)
				d.stopDet = 1'b0;
			if (stopSeen)
			begin
				d.stopDet = 1'b1;
				d.masterSt = 1'b0;
				d.addrMatch = 1'b0;
				d.extCode = 1'b0;
				d.txMode = 1'b0;
				d.waitHold = 1'b0;
				d.ackDrive = 1'b0;
				d.standby = 1'b0;
				if (q.ctrl[`BIT_SPIE])
					d.irq = 1'b1;
			end
			if (startSeen && !q.masterSt)
			begin
				d.addrMatch = 1'b0;
				d.extCode = 1'b0;
				d.txMode = 1'b0;
			end
			if (fall8)
			begin
				if (addrPhase && !q.masterSt)
				begin
					d.addrMatch = matchNow;
					d.extCode = extNow;
					d.txMode = matchNow & rxByte[0];
					if (matchNow || extNow)
						d.standby = 1'b0;
				end
				else if (addrPhase)
					d.txMode = !rxByte[0];
				involved = d.masterSt | d.addrMatch | d.extCode;
				waitAt8 = addrPhase ? (d.extCode & !q.masterSt) : !q.ctrl[`BIT_WTIM];
				if (involved && !d.standby)
				begin
					if (q.ctrl[`BIT_ACKE] && !d.txMode)
						d.ackDrive = 1'b1;
					if (waitAt8)
					begin
						d.waitHold = 1'b1;
						d.wait9 = 1'b0;
						d.irq = 1'b1;
					end
				end
			end
			if (rise9 && involved && ackLow)
				d.ackDet = 1'b1;
			if (fall9)
			begin
				d.ackDrive = 1'b0;
				waitAt8 = addrPhase ? (q.extCode & !q.masterSt) : !q.ctrl[`BIT_WTIM];
				if (involved && !q.standby && (addrPhase || !waitAt8))
				begin
					d.waitHold = 1'b1;
					d.wait9 = 1'b1;
					d.irq = 1'b1;
				end
			end
			if (q.ctrl[`BIT_WREL])
			begin
				d.waitHold = 1'b0;
				if (q.waitHold && q.wait9 && q.txMode)
					d.txMode = 1'b0;
				d.ctrl[`BIT_WREL] = 1'b0;
			end
			// start and stop generation
			unique case (q.genState)
				i2c_ctl_pkg::GEN_IDLE:
				begin
					if (q.ctrl[`BIT_START])
					begin
						if (monBusy)
						begin
							d.startFailed = 1'b1;
							d.ctrl[`BIT_START] = 1'b0;
						end
						else
						begin
							d.startFailed = 1'b0;
							d.holdCount = 9'h000;
							d.genState = i2c_ctl_pkg::GEN_START;
						end
					end
					else if (q.ctrl[`BIT_STOP])
					begin
						d.waitHold = 1'b0;
						d.holdCount = 9'h000;
						d.genState = i2c_ctl_pkg::GEN_STOP_LOW;
					end
				end
				i2c_ctl_pkg::GEN_START:
				begin
					d.holdCount = q.holdCount + 9'h001;
					if (q.holdCount == 9'(`START_HOLD_CYC - 1))
					begin
						d.masterSt = 1'b1;
						d.waitHold = 1'b1;
						d.wait9 = 1'b0;
						d.genState = i2c_ctl_pkg::GEN_START_SCL;
					end
				end
				i2c_ctl_pkg::GEN_START_SCL:
				begin
					if (!sclLevel)
					begin
						d.ctrl[`BIT_START] = 1'b0;
						d.genState = i2c_ctl_pkg::GEN_IDLE;
					end
				end
				i2c_ctl_pkg::GEN_STOP_LOW:
				begin
					d.waitHold = 1'b0;
					if (sclLevel)
						d.genState = i2c_ctl_pkg::GEN_STOP_HOLD;
				end
				i2c_ctl_pkg::GEN_STOP_HOLD:
				begin
					d.holdCount = q.holdCount + 9'h001;
					if (q.holdCount == 9'(`STOP_SETUP_CYC - 1))
					begin
						d.ctrl[`BIT_STOP] = 1'b0;
						d.genState = i2c_ctl_pkg::GEN_IDLE;
					end
				end
			endcase
			if (q.ctrl[`BIT_EXIT])
			begin
				d.standby = 1'b1;
				d.waitHold = 1'b0;
				d.ackDrive = 1'b0;
				d.genState = i2c_ctl_pkg::GEN_IDLE;
				d.stopDet = d.stopDet & stopSeen;
				d.ackDet = 1'b0;
				d.txMode = 1'b0;
				d.addrMatch = 1'b0;
				d.extCode = 1'b0;
				d.masterSt = 1'b0;
				d.ctrl[`BIT_START] = 1'b0;
				d.ctrl[`BIT_STOP] = 1'b0;
				d.ctrl[`BIT_EXIT] = 1'b0;
			end
		end
		if (hit && cpuWrByte)
			d.ctrl = cpuWrData;
		else if (hit && cpuWrBit)
			d.ctrl[cpuBitSel] = cpuBitVal;
		if (!enabled)
			d.irq = 1'b0;
		// pin drive
		d.sclOe = d.waitHold;
		d.sdaOe = d.ackDrive
			| (d.genState == i2c_ctl_pkg::GEN_START)
			| (d.genState == i2c_ctl_pkg::GEN_START_SCL)
			| (d.genState == i2c_ctl_pkg::GEN_STOP_LOW)
			| (d.genState == i2c_ctl_pkg::GEN_STOP_HOLD)
			| (d.waitHold & d.wait9 & d.txMode & !txFirstBit);
		// read port
		if (cpuRd)
			d.rdData = hit ? q.ctrl : 8'h00;
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.ctrl <= `CTRL_RESET;
		end
		else if (clkEn)
			q <= d;
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	// enable is bit 7
	assign enabled = q.ctrl[`BIT_ENABLE];
	assign cpuRdData = q.rdData;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = q.sclOe;
	assign sdaOe = q.sdaOe;
	always_comb
	begin
		statusReg = 8'h00;
		statusReg[`ST_MASTER] = q.masterSt;
		statusReg[`ST_EXT] = q.extCode;
		statusReg[`ST_MATCH] = q.addrMatch;
		statusReg[`ST_TX] = q.txMode;
		statusReg[`ST_ACK] = q.ackDet;
		statusReg[`ST_STOP] = q.stopDet;
	end
	assign startFailed = q.startFailed;
	// levels and busy cleared while disabled
	assign busBusy = enabled & monBusy;
	assign clockLineLevel = enabled & sclLevel;
	assign dataLineLevel = enabled & sdaLevel;
	assign twoWireInterrupt = q.irq;

endmodule

`default_nettype wire

// [logic/i2c_ctl_cfg.svh]
`ifndef I2C_CTL_CFG_SVH
`define I2C_CTL_CFG_SVH

// --------------------------------------------------------------
// register placement
// --------------------------------------------------------------
`define CTRL_ADDR 16'hFFA6
`define CTRL_RESET 8'h00

// --------------------------------------------------------------
// control register bit positions
// --------------------------------------------------------------
`define BIT_ENABLE 7
`define BIT_EXIT 6
`define BIT_WREL 5
`define BIT_SPIE 4
`define BIT_WTIM 3
`define BIT_ACKE 2
`define BIT_START 1
`define BIT_STOP 0

// --------------------------------------------------------------
// status register bit positions
// --------------------------------------------------------------
`define ST_MASTER 7
`define ST_EXT 5
`define ST_MATCH 4
`define ST_TX 3
`define ST_ACK 2
`define ST_STOP 1

// --------------------------------------------------------------
// bus constants and timing
// --------------------------------------------------------------
`define EXT_CODE_PREFIX 5'h1E
`define MON_PRE 4'hF
`define SYS_CLK_MHZ 100
`define START_HOLD_NS 4000
`define STOP_SETUP_NS 4000
`define START_HOLD_CYC ((`START_HOLD_NS * `SYS_CLK_MHZ + 999) / 1000)
`define STOP_SETUP_CYC ((`STOP_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// [logic/i2c_ctl_pkg.sv]
`default_nettype none

package i2c_ctl_pkg;

	typedef enum logic [2:0] {
		GEN_IDLE,
		GEN_START,
		GEN_START_SCL,
		GEN_STOP_LOW,
		GEN_STOP_HOLD
	} gen_state_t;

	typedef struct packed {
		logic [1:0] sclSync;
		logic [1:0] sdaSync;
		logic sclLast;
		logic sdaLast;
		logic busBusy;
		logic addrPhase;
		logic [3:0] fallCount;
		logic [7:0] rxByte;
		logic ackLow;
		logic startSeen;
		logic stopSeen;
		logic fall8;
		logic fall9;
		logic rise9;
	} mon_state_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic stopDet;
		logic ackDet;
		logic txMode;
		logic addrMatch;
		logic extCode;
		logic masterSt;
		logic startFailed;
		logic standby;
		logic waitHold;
		logic wait9;
		logic ackDrive;
		logic sclOe;
		logic sdaOe;
		gen_state_t genState;
		logic [8:0] holdCount;
		logic irq;
		logic [7:0] rdData;
	} ctl_state_t;

endpackage

`default_nettype wire

// [tb/i2c_control_register_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "i2c_ctl_cfg.svh"

module i2c_control_register_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// cpu side
	input wire logic [15:0] cpuAddr,
	input wire logic cpuWrByte,
	input wire logic [7:0] cpuWrData,
	input wire logic cpuRd,
	input wire logic [7:0] cpuRdData,
	// bus and status side
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [7:0] statusReg,
	input wire logic startFailed,
	input wire logic busBusy,
	input wire logic clockLineLevel,
	input wire logic dataLineLevel,
	input wire logic twoWireInterrupt
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// ----
	// control writes
	// ----
	sequence ctlWr;
		clkEn && cpuWrByte && cpuAddr == `CTRL_ADDR;
	endsequence

	chk_unmapped_read: assert property (clkEn && cpuRd && cpuAddr != `CTRL_ADDR |=> cpuRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_disable_clears: assert property (ctlWr ##0 !cpuWrData[7] |-> ##3 (statusReg == 8'h00 && !busBusy && !startFailed && !clockLineLevel && !dataLineLevel))
		else $error("disable left state set");
	chk_exit_release: assert property (ctlWr ##0 cpuWrData[7:6] == 2'b11 |-> ##4 (!sclOe && !sdaOe))
		else $error("exit kept lines driven");
	chk_wait_release: assert property (ctlWr ##0 (cpuWrData[7:5] == 3'b101 && cpuWrData[1:0] == 2'b00 && sclOe) |-> ##4 !sclOe)
		else $error("wait release kept clock low");
	chk_open_drain: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
		else $error("pin driven high");
	chk_irq_pulse: assert property (twoWireInterrupt |=> !twoWireInterrupt)
		else $error("interrupt longer than one cycle");
	chk_wait_irq: assert property ($rose(sclOe) && !sdaOe && !statusReg[7] |-> twoWireInterrupt)
		else $error("wait without interrupt");
	chk_disabled_ignore: assert property (ctlWr ##0 (!cpuWrData[7] && cpuWrData[6:4] != 3'b000) |-> ##2 (!twoWireInterrupt && !sclOe && !sdaOe)[*4])
		else $error("disabled bits took effect");
endmodule

bind i2c_control_register i2c_control_register_monitor i_mon (.sys_clk, .rst_b, .clkEn, .cpuAddr,
	.cpuWrByte, .cpuWrData, .cpuRd, .cpuRdData, .sclOut, .sclOe, .sdaOut, .sdaOe, .statusReg,
	.startFailed, .busBusy, .clockLineLevel, .dataLineLevel, .twoWireInterrupt);

`default_nettype wire

// [tb/i2c_far_master.sv]
`timescale 1ns/100ps
`default_nettype none

module i2c_far_master (
	// wire levels
	input wire logic sclLine,
	input wire logic sdaLine,
	// open-drain pull-downs
	output logic sclLow,
	output logic sdaLow
);
	// ----
	// bus master frames, clock idle between them
	// ----
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end

	// release clock and honour stretching, bounded
	task automatic sclUp();
		int n;
		sclLow = 1'b0;
		n = 0;
		while (sclLine !== 1'b1 && n < 5000)
		begin
			#10;
			n++;
		end
		#62.5;
	endtask

	task automatic startCond();
		sdaLow = 1'b1;
		#62.5;
		sclLow = 1'b1;
		#62.5;
	endtask

	// eight data bits msb first, ninth clock with data released
	task automatic sendByte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--)
		begin
			sdaLow = (i > 0) ? !b[i-1] : 1'b0;
			#31.25;
			sclUp();
			sclLow = 1'b1;
			#31.25;
		end
	endtask

	task automatic stopCond();
		sdaLow = 1'b1;
		#31.25;
		sclUp();
		sdaLow = 1'b0;
		#62.5;
	endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "i2c_ctl_cfg.svh"

module testbench;
	logic sys_clk, rst_b, clkEn, cpuWrByte, cpuWrBit, cpuBitVal, cpuRd, txFirstBit;
	logic [15:0] cpuAddr;
	logic [7:0] cpuWrData, cpuRdData, statusReg;
	logic [2:0] cpuBitSel;
	logic [6:0] slaveAddr;
	logic sclOut, sclOe, sdaOut, sdaOe, startFailed, busBusy, clockLineLevel, dataLineLevel;
	logic twoWireInterrupt, sclLow, sdaLow, sclWire, sdaWire;
	int errors = 0, comparisons = 0, irqCount = 0, base;

	// pulled-up bus lines
	assign sclWire = !(sclOe || sclLow);
	assign sdaWire = !(sdaOe || sdaLow);

	i2c_control_register i_i2c_control_register (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
		.cpuAddr(cpuAddr), .cpuWrByte(cpuWrByte), .cpuWrData(cpuWrData), .cpuWrBit(cpuWrBit),
		.cpuBitSel(cpuBitSel), .cpuBitVal(cpuBitVal), .cpuRd(cpuRd), .cpuRdData(cpuRdData),
		.slaveAddr(slaveAddr), .txFirstBit(txFirstBit), .sclIn(sclWire), .sclOut(sclOut),
		.sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .statusReg(statusReg),
		.startFailed(startFailed), .busBusy(busBusy), .clockLineLevel(clockLineLevel),
		.dataLineLevel(dataLineLevel), .twoWireInterrupt(twoWireInterrupt));
	i2c_far_master i_i2c_far_master (.sclLine(sclWire), .sdaLine(sdaWire), .sclLow(sclLow),
		.sdaLow(sdaLow));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		if (twoWireInterrupt === 1'b1)
			irqCount <= irqCount + 1;

	// ----
	// shared tasks
	// ----
	task automatic final_report();
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wrByte(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cpuAddr <= a;
		cpuWrData <= d;
		cpuWrByte <= 1'b1;
		@(posedge sys_clk);
		cpuWrByte <= 1'b0;
	endtask

	task automatic wrBit(input logic [2:0] s, input logic v);
		@(posedge sys_clk);
		cpuAddr <= `CTRL_ADDR;
		cpuBitSel <= s;
		cpuBitVal <= v;
		cpuWrBit <= 1'b1;
		@(posedge sys_clk);
		cpuWrBit <= 1'b0;
	endtask

	task automatic rdCheck(input string name, input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		cpuAddr <= a;
		cpuRd <= 1'b1;
		@(posedge sys_clk);
		cpuRd <= 1'b0;
		@(posedge sys_clk);
		check(name, exp, cpuRdData);
	endtask

	// which 0: clock held, 1: master flag
	task automatic waitFor(input int which);
		int n;
		n = 0;
		while ((which == 0 ? sclOe : statusReg[7]) !== 1'b1)
		begin
			@(posedge sys_clk);
			n++;
			if (n > 1000)
			begin
				errors++;
				final_report();
			end
		end
	endtask

	// ----
	// scenarios
	// ----
	task automatic s_reset_regs();
		rdCheck("ctrl after reset", `CTRL_ADDR, 8'h00);
		rdCheck("unmapped read", 16'hFFA7, 8'h00);
		wrByte(16'hFFA5, 8'h9C);
		rdCheck("ctrl after stray write", `CTRL_ADDR, 8'h00);
	endtask

	task automatic s_byte_bit();
		wrByte(`CTRL_ADDR, 8'h1C);
		rdCheck("byte write", `CTRL_ADDR, 8'h1C);
		rdCheck("unmapped after write", 16'hFFA7, 8'h00);
		wrBit(3'h7, 1'b1);
		rdCheck("bit set", `CTRL_ADDR, 8'h9C);
		check("clock level", 8'h01, {7'h00, clockLineLevel});
		wrBit(3'h2, 1'b0);
		rdCheck("bit clear", `CTRL_ADDR, 8'h98);
		wrByte(`CTRL_ADDR, 8'h70);
		rdCheck("disabled self clear", `CTRL_ADDR, 8'h10);
	endtask

	task automatic s_disable();
		wrByte(`CTRL_ADDR, 8'h98);
		repeat (4) @(posedge sys_clk);
		check("data level", 8'h01, {7'h00, dataLineLevel});
		i_i2c_far_master.startCond();
		repeat (6) @(posedge sys_clk);
		check("busy after start", 8'h01, {7'h00, busBusy});
		wrByte(`CTRL_ADDR, 8'h00);
		repeat (2) @(posedge sys_clk);
		check("busy cleared", 8'h00, {7'h00, busBusy});
		i_i2c_far_master.stopCond();
		repeat (6) @(posedge sys_clk);
		check("levels cleared", 8'h00, {6'h00, clockLineLevel, dataLineLevel});
	endtask

	task automatic s_exit();
		wrByte(`CTRL_ADDR, 8'h98);
		i_i2c_far_master.startCond();
		i_i2c_far_master.sendByte({slaveAddr, 1'b0});
		waitFor(0);
		wrByte(`CTRL_ADDR, 8'hD8);
		repeat (4) @(posedge sys_clk);
		check("exit lines", 8'h00, {6'h00, sclOe, sdaOe});
		check("exit flags", 8'h00, statusReg);
		rdCheck("exit cleared", `CTRL_ADDR, 8'h98);
		i_i2c_far_master.sendByte({slaveAddr, 1'b0});
		repeat (4) @(posedge sys_clk);
		check("standby ignores", 8'h00, {statusReg[7:1], sclOe});
		i_i2c_far_master.stopCond();
	endtask

	task automatic s_slave_wait();
		base = irqCount;
		i_i2c_far_master.startCond();
		i_i2c_far_master.sendByte({slaveAddr, 1'b0});
		waitFor(0);
		repeat (2) @(posedge sys_clk);
		check("match flag", 8'h10, statusReg & 8'h10);
		check("wait irq", 8'h01, 8'(irqCount - base));
		fork
			i_i2c_far_master.stopCond();
			wrByte(`CTRL_ADDR, 8'hB8);
		join
		rdCheck("release cleared", `CTRL_ADDR, 8'h98);
		repeat (6) @(posedge sys_clk);
		check("stop irq", 8'h02, 8'(irqCount - base));
		check("stop flag", 8'h02, statusReg & 8'h02);
	endtask

	task automatic s_tx_release();
		txFirstBit <= 1'b0;
		i_i2c_far_master.startCond();
		i_i2c_far_master.sendByte({slaveAddr, 1'b1});
		waitFor(0);
		repeat (2) @(posedge sys_clk);
		check("tx flag", 8'h08, statusReg & 8'h08);
		check("tx data drive", 8'h01, {7'h00, sdaOe});
		wrByte(`CTRL_ADDR, 8'hB8);
		repeat (3) @(posedge sys_clk);
		check("tx released", 8'h00, {statusReg[3], 5'h00, sclOe, sdaOe});
		txFirstBit <= 1'b1;
		i_i2c_far_master.stopCond();
	endtask

	task automatic s_start_trigger();
		wrByte(`CTRL_ADDR, 8'h9A);
		repeat (3) @(posedge sys_clk);
		check("start drive", 8'h01, {7'h00, sdaOe});
		waitFor(1);
		repeat (4) @(posedge sys_clk);
		wrBit(3'h1, 1'b1);
		repeat (2) @(posedge sys_clk);
		check("start failed", 8'h01, {7'h00, startFailed});
		rdCheck("start refused", `CTRL_ADDR, 8'h98);
		wrByte(`CTRL_ADDR, 8'hD8);
		repeat (4) @(posedge sys_clk);
		check("master cleared", 8'h00, statusReg);
		wrByte(`CTRL_ADDR, 8'h00);
		repeat (2) @(posedge sys_clk);
		check("start failed cleared", 8'h00, {7'h00, startFailed});
	endtask

	initial
	begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		cpuAddr = 16'h0000;
		cpuWrByte = 1'b0;
		cpuWrData = 8'h00;
		cpuWrBit = 1'b0;
		cpuBitSel = 3'h0;
		cpuBitVal = 1'b0;
		cpuRd = 1'b0;
		slaveAddr = 7'h2A;
		txFirstBit = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		s_reset_regs();
		s_byte_bit();
		s_disable();
		s_exit();
		s_slave_wait();
		s_tx_release();
		s_start_trigger();
		final_report();
	end
endmodule

`default_nettype wire
